// [inc/chained_io_extender_map.svh]
// constants for the chained extender bus: slot codes, field positions, widths
// assumes inclusion by bare name from design files
`ifndef CHAINED_IO_EXTENDER_MAP_SVH
`define CHAINED_IO_EXTENDER_MAP_SVH
`define WORD_W 16
`define DATA_W 12
`define SLOT_MSB 15
`define SLOT_LSB 12
`define SLOT_W 4
`define SLOT_COUNT 15
`define CONTROL_SLOT_CODE 4'hf
`define USEL_W 15
`define USEL_FWD_W 14
`define WORD_RESET 16'h0000
`endif

// [inc/chained_io_extender_pkg.sv]
// types for the chained extender bus
// assumes the map header provides widths
`include "chained_io_extender_map.svh"
package chained_io_extender_pkg;
  typedef logic [`SLOT_W-1:0] slot_t;
  typedef logic [`DATA_W-1:0] data_t;
  typedef logic [`SLOT_COUNT-1:0] slot_vec_t;
endpackage

// [src/sync2.sv]
// two-flop synchroniser for a vector of pin levels
// assumes clk_i is the only clock; reset is the already released copy
`timescale 1ns/1ns
module sync2 #(
  parameter int W = 1
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] q;
  } sync_s;
  sync_s state_reg;
  sync_s state_next;
  always_comb begin
    state_next = state_reg;
    state_next.meta = d_i;
    state_next.q = state_reg.meta;
  end
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end
  assign q_o = state_reg.q;
endmodule

// [src/chained_io_extender_bus.sv]
// one extender unit: word, strobe, mode, select bit 0 and flag pins enter on clk_i through two flops
// assumes clk_i far faster than strobe; card logic outside uses the strobes
`timescale 1ns/1ns
`include "chained_io_extender_map.svh"
module chained_io_extender_bus (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic [`WORD_W-1:0] word_n_i,
  output logic [`DATA_W-1:0] word_data_n_o,
  output logic word_data_oe_o,
  input wire logic transfer_strobe_n_i,
  input wire logic input_direction_select_i,
  input wire logic interrupt_permit_mode_i,
  input wire logic transfer_release_mode_i,
  input wire logic timed_flag_mode_i,
  input wire logic system_output_enable_i,
  output logic input_direction_select_o,
  output logic interrupt_permit_mode_o,
  output logic transfer_release_mode_o,
  output logic timed_flag_mode_o,
  output logic system_output_enable_o,
  input wire logic [`USEL_W-1:0] unit_select_i,
  output logic [`USEL_FWD_W-1:0] unit_select_o,
  input wire logic input_request_n_i,
  output logic input_request_n_o,
  input wire logic ready_flag_merge_i,
  input wire logic local_ready_i,
  output logic ready_flag_out_o,
  output logic [`SLOT_COUNT-1:0] card_enable_o,
  output logic [`SLOT_COUNT-1:0] card_load_o,
  output logic [`SLOT_COUNT-1:0] card_gate_enable_o,
  output logic [`SLOT_COUNT-1:0] card_reset_o,
  output logic [`DATA_W-1:0] card_data_o,
  input wire logic [`DATA_W-1:0] card_return_data_i,
  output logic [`DATA_W-1:0] downstream_data_n_o,
  output logic downstream_data_oe_o,
  input wire logic [`DATA_W-1:0] downstream_data_n_i,
  output logic unit_enable_o
);
  localparam int SW = `WORD_W + 1 + 5 + 1 + 1 + 1;
  typedef struct packed {
    logic strobe_prev;
    logic [`SLOT_COUNT-1:0] load;
    logic [`SLOT_COUNT-1:0] gate_en;
    logic [`SLOT_COUNT-1:0] reset;
    logic [`DATA_W-1:0] data;
    logic [`DATA_W-1:0] up_data_n;
  } unit_s;
  unit_s state_reg;
  unit_s state_next;
  logic rst_n;
  logic [SW-1:0] pins_s;
  logic [`WORD_W-1:0] word_s;
  logic strobe_n_s;
  logic isl_s;
  logic ien_s;
  logic dte_s;
  logic tme_s;
  logic sye_s;
  logic own_sel_s;
  logic merge_s;
  logic ready_s;
  logic [`WORD_W-1:0] word_true;
  chained_io_extender_pkg::slot_t slot;
  logic strobe_fall;
  logic word_meaningful;
  chained_io_extender_pkg::slot_vec_t slot_hit;
  logic [1:0] rst_chain;

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_chain <= 2'h0;
    end else begin
      rst_chain <= {rst_chain[0], 1'b1};
    end
  end
  assign rst_n = rst_chain[1];

  sync2 #(.W(SW)) u_sync (
    .clk_i(clk_i),
    .rst_n_i(rst_n),
    .d_i({word_n_i, transfer_strobe_n_i, input_direction_select_i, interrupt_permit_mode_i,
          transfer_release_mode_i, timed_flag_mode_i, system_output_enable_i, unit_select_i[0],
          ready_flag_merge_i, local_ready_i}),
    .q_o(pins_s)
  );
  assign {word_s, strobe_n_s, isl_s, ien_s, dte_s, tme_s, sye_s, own_sel_s, merge_s, ready_s} = pins_s;

  // bus is low-true; invert once here
  assign word_true = ~word_s;
  assign slot = word_true[`SLOT_MSB:`SLOT_LSB];
  assign word_meaningful = (slot != `CONTROL_SLOT_CODE);
  assign strobe_fall = state_reg.strobe_prev && !strobe_n_s;

  genvar g;
  generate
    for (g = 0; g < `SLOT_COUNT; g++) begin : g_slot
      // slot position g answers address g
      assign slot_hit[g] = own_sel_s && word_meaningful && (slot == chained_io_extender_pkg::slot_t'(g));
    end
  endgenerate

  always_comb begin
    state_next = state_reg;
    state_next.strobe_prev = strobe_n_s;
    state_next.load = '0;
    state_next.gate_en = '0;
    state_next.reset = '0;
    if (strobe_fall) begin
      if (!isl_s) begin
        state_next.load = slot_hit;
        // an input card in this slot resets on an output-mode strobe
        state_next.reset = slot_hit;
        if (|slot_hit) begin
          state_next.data = word_true[`DATA_W-1:0];
        end
      end else begin
        state_next.gate_en = slot_hit;
      end
    end
    // returned input data, driven low-true toward master
    state_next.up_data_n = ~card_return_data_i;
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= '0;
      // synced strobe resets low: no edge until it has been seen high
      state_reg.strobe_prev <= 1'b0;
      state_reg.up_data_n <= '1;
    end else begin
      state_reg <= state_next;
    end
  end

  assign card_load_o = state_reg.load;
  assign card_gate_enable_o = state_reg.gate_en;
  assign card_reset_o = state_reg.reset;
  assign card_data_o = state_reg.data;
  assign card_enable_o = {`SLOT_COUNT{own_sel_s}};
  assign unit_enable_o = own_sel_s;

  // mode lines pass straight through; select lines shift down one position
  assign input_direction_select_o = input_direction_select_i;
  assign interrupt_permit_mode_o = interrupt_permit_mode_i;
  assign transfer_release_mode_o = transfer_release_mode_i;
  assign timed_flag_mode_o = timed_flag_mode_i;
  assign system_output_enable_o = system_output_enable_i;
  assign unit_select_o = unit_select_i[`USEL_W-1:1];
  assign input_request_n_o = input_request_n_i;

  // flag meaning set by local card logic per modes; merged with downstream
  assign ready_flag_out_o = ready_s || merge_s;

  // direction of the data lines
  assign downstream_data_n_o = word_s[`DATA_W-1:0];
  assign downstream_data_oe_o = !isl_s;
  assign word_data_n_o = (own_sel_s && isl_s) ? state_reg.up_data_n : downstream_data_n_i;
  assign word_data_oe_o = isl_s;

  chk_strobe_load: assert property (@(posedge clk_i) disable iff (!rst_n)
    (strobe_fall && !isl_s && |slot_hit) |=> (card_load_o != '0 && card_data_o == $past(word_true[`DATA_W-1:0])))
    else $error("addressed output card not loaded");
  chk_control_ignored: assert property (@(posedge clk_i) disable iff (!rst_n)
    (slot == `CONTROL_SLOT_CODE) |=> (card_load_o == '0 && card_gate_enable_o == '0 && card_reset_o == '0))
    else $error("control word acted on");
  chk_one_hot_slot: assert property (@(posedge clk_i) disable iff (!rst_n)
    $onehot0(card_load_o | card_gate_enable_o | card_reset_o))
    else $error("more than one slot enabled");
  chk_no_edge_idle: assert property (@(posedge clk_i) disable iff (!rst_n)
    !(state_reg.strobe_prev && !strobe_n_s) |=> (card_load_o == '0 && card_reset_o == '0))
    else $error("card action without strobe edge");
  chk_input_mode_split: assert property (@(posedge clk_i) disable iff (!rst_n)
    (strobe_fall && isl_s && |slot_hit) |=> (card_gate_enable_o != '0 && card_reset_o == '0 && card_load_o == '0))
    else $error("input card action wrong");
  chk_output_mode_reset: assert property (@(posedge clk_i) disable iff (!rst_n)
    (strobe_fall && !isl_s && |slot_hit) |=> (card_reset_o != '0 && card_gate_enable_o == '0))
    else $error("input card not reset in output mode");
  chk_unit_gate: assert property (@(posedge clk_i) disable iff (!rst_n)
    !own_sel_s |=> (card_load_o == '0 && card_gate_enable_o == '0 && card_reset_o == '0))
    else $error("unselected unit acted");
  chk_select_shift: assert property (@(posedge clk_i) disable iff (!rst_n)
    unit_select_o == unit_select_i[`USEL_W-1:1])
    else $error("select lines not shifted");
  chk_direction: assert property (@(posedge clk_i) disable iff (!rst_n)
    downstream_data_oe_o != word_data_oe_o)
    else $error("both data directions enabled");
  chk_flag_merge: assert property (@(posedge clk_i) disable iff (!rst_n)
    merge_s |-> ready_flag_out_o)
    else $error("downstream flag lost");
endmodule

// [dv/ext_master_model.sv]
// upstream master model: word bus, transfer strobe and one-hot unit select
// assumes the bench calls its tasks at the falling clock edge
`timescale 1ns/1ns
module ext_master_model (
  input wire logic clk_i,
  output logic [15:0] word_n_o,
  output logic strobe_n_o,
  output logic [14:0] unit_select_o
);
  initial begin
    word_n_o = 16'hffff;
    strobe_n_o = 1'b1;
    unit_select_o = 15'h0000;
  end
  // selection held until the next select_unit call
  task automatic select_unit(input int u);
    unit_select_o = 15'h0001 << u;
  endtask
  // low-true word, slot in the top bits, stable well before the fall
  task automatic send(input logic [3:0] slot, input logic [11:0] data);
    word_n_o = ~{slot, data};
    repeat (4) @(negedge clk_i);
    strobe_n_o = 1'b0;
    repeat (8) @(negedge clk_i);
    strobe_n_o = 1'b1;
    repeat (2) @(negedge clk_i);
    word_n_o = {slot, data};
    repeat (4) @(negedge clk_i);
  endtask
endmodule

// [dv/chained_io_extender_bus_tb_top.sv]
// self-checking bench for one extender unit
// assumes the master model drives word, strobe and unit select
`timescale 1ns/1ns
module chained_io_extender_bus_tb_top;
  logic clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic input_direction_select = 1'b0, interrupt_permit_mode = 1'b0, transfer_release_mode = 1'b0, timed_flag_mode = 1'b0, system_output_enable = 1'b0;
  logic irq_n = 1'b1, merge = 1'b0, lrdy = 1'b0;
  logic [11:0] ret = 12'h000, dsd = 12'h000, d;
  logic [15:0] word_n;
  logic strobe_n;
  logic [14:0] usel, cen, ld, ge, rs, s_ld, s_ge, s_rs;
  logic [13:0] usel_o;
  logic [11:0] wd_n, cdata, dsd_n;
  logic wd_oe, ds_oe, uen, flag, irq_o, m0, m1, m2, m3, m4;
  int miscompares = 0;
  int cmp_count = 0;
  initial forever #2 clk_i = ~clk_i;
  ext_master_model u_ext_master_model (.clk_i(clk_i), .word_n_o(word_n), .strobe_n_o(strobe_n),
    .unit_select_o(usel));
  chained_io_extender_bus u_chained_io_extender_bus (.clk_i(clk_i), .reset_n_i(reset_n_i),
    .word_n_i(word_n), .word_data_n_o(wd_n), .word_data_oe_o(wd_oe), .transfer_strobe_n_i(strobe_n),
    .input_direction_select_i(input_direction_select), .interrupt_permit_mode_i(interrupt_permit_mode), .transfer_release_mode_i(transfer_release_mode),
    .timed_flag_mode_i(timed_flag_mode), .system_output_enable_i(system_output_enable), .input_direction_select_o(m0),
    .interrupt_permit_mode_o(m1), .transfer_release_mode_o(m2), .timed_flag_mode_o(m3),
    .system_output_enable_o(m4), .unit_select_i(usel), .unit_select_o(usel_o),
    .input_request_n_i(irq_n), .input_request_n_o(irq_o), .ready_flag_merge_i(merge),
    .local_ready_i(lrdy), .ready_flag_out_o(flag), .card_enable_o(cen), .card_load_o(ld),
    .card_gate_enable_o(ge), .card_reset_o(rs), .card_data_o(cdata), .card_return_data_i(ret),
    .downstream_data_n_o(dsd_n), .downstream_data_oe_o(ds_oe), .downstream_data_n_i(dsd),
    .unit_enable_o(uen));
  // gather every card pulse seen during one transfer
  always @(posedge clk_i) begin
    s_ld |= ld;
    s_ge |= ge;
    s_rs |= rs;
  end
  function automatic logic [14:0] hot(input logic [3:0] s);
    return (s == 4'hf) ? 15'h0000 : (15'h0001 << s);
  endfunction
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic xfer(input logic [3:0] s, input logic [11:0] dv);
    s_ld = 15'h0000;
    s_ge = 15'h0000;
    s_rs = 15'h0000;
    u_ext_master_model.send(s, dv);
  endtask
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    #200000;
    miscompares++;
    summarize();
  end
  initial begin
    void'($urandom(98));
    repeat (8) @(negedge clk_i);
    reset_n_i = 1'b1;
    u_ext_master_model.select_unit(0);
    repeat (6) @(negedge clk_i);
    check({uen, cen}, 16'hffff);
    for (int i = 0; i < 16; i++) begin
      d = $urandom;
      xfer(i[3:0], d);
      check(s_ld, hot(i[3:0]));
      check(s_ge, 16'h0000);
      check(s_rs, hot(i[3:0]));
      if (i < 15) check(cdata, d);
    end
    u_ext_master_model.select_unit(1 + $urandom % 14);
    repeat (4) @(negedge clk_i);
    check({uen, cen}, 16'h0000);
    check(usel_o, usel[14:1]);
    xfer($urandom % 15, $urandom);
    check(s_ld | s_ge | s_rs, 16'h0000);
    dsd = $urandom;
    input_direction_select = 1'b1;
    repeat (5) @(negedge clk_i);
    check(wd_n, dsd);
    u_ext_master_model.select_unit(0);
    for (int k = 0; k < 2; k++) begin
      interrupt_permit_mode = k[0];
      xfer(4'h3, 12'h000);
      check(s_ge, hot(4'h3));
      check(s_rs | s_ld, 16'h0000);
    end
    ret = $urandom;
    repeat (5) @(negedge clk_i);
    check({4'h0, wd_n}, {4'h0, ~ret});
    check({wd_oe, ds_oe}, 2'b10);
    input_direction_select = 1'b0;
    repeat (5) @(negedge clk_i);
    check({wd_oe, ds_oe}, 2'b01);
    check(dsd_n, word_n[11:0]);
    for (int k = 0; k < 8; k++) begin
      {input_direction_select, interrupt_permit_mode, transfer_release_mode, timed_flag_mode, system_output_enable, irq_n, merge, lrdy} = $urandom;
      repeat (4) @(negedge clk_i);
      check({m0, m1, m2, m3, m4}, {input_direction_select, interrupt_permit_mode, transfer_release_mode, timed_flag_mode, system_output_enable});
      check(irq_o, irq_n);
      check(flag, merge | lrdy);
    end
    summarize();
  end
endmodule
